/* File: design/timer_map.svh */
// Register indices, field positions, reset values, counter limits, PWM masks and bus responses of the dual timer
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
// Register indices; byte address is four times the index
`define IDX_A_CTRL 8'hd8
`define IDX_A_CNT 8'hd9
`define IDX_B_CTRL 8'hdc
`define IDX_B_CNT 8'hdd
`define IDX_B_RELOAD 8'hde
`define IDX_IRQ 8'he0
// Control register fields
`define F_RUN 7
`define F_RATE_HI 6
`define F_RATE_LO 4
`define F_SRC 3
`define F_ALOAD 2
`define F_TOGGLE 1
`define F_PWM 0
// Interrupt flag and enable register fields
`define F_A_FLAG 0
`define F_A_IEN 1
`define F_B_FLAG 2
`define F_B_IEN 3
`define F_EXT_FLAG 4
// Reset value and counter limits
`define RST_BYTE 8'h00
`define CNT_MAX 8'hff
// PWM boundary masks for N = 256, 64, 32, 16
`define MASK_256 8'hff
`define MASK_64 8'h3f
`define MASK_32 8'h1f
`define MASK_16 8'h0f
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: design/timer_pkg.sv */
// Types shared by the dual timer design
package timer_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] rate_t;
   typedef enum logic [1:0] {WAVE_IO = 2'b00, WAVE_TOGGLE = 2'b01, WAVE_PWM = 2'b11} wave_sel_t;
endpackage : timer_pkg

/* File: design/presc_if.sv */
// Rate select and tick between a timer and its prescaler
interface presc_if;
   logic [2:0] sel;
   logic tick;
   modport user (output sel, input tick);
   modport gen (input sel, output tick);
endinterface : presc_if

/* File: design/prescaler.sv */
// Free-running divider giving one tick every 2^(8-sel) clocks
`include "timer_map.svh"
module prescaler
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Rate select and tick
   presc_if.gen p
);
   logic [7:0] div_r;
   logic [7:0] mask;

   // Free-running divider
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         div_r <= `RST_BYTE;
      else
         div_r <= div_r + 8'h01;
   end

   // Code 000 needs all eight bits set (256), each step up drops one bit
   assign mask = 8'hff >> p.sel; // RULE_01 RULE_13
   assign p.tick = (div_r & mask) == mask;
endmodule : prescaler

/* File: design/dual_timer.sv */
// Dual 8-bit timer with event counting, auto-reload, toggle and PWM output
//
// Implementation choice: register access over AXI4-Lite.
`include "timer_map.svh"
// Operation
// RULE_01: Timer A tick is CPU clock divided by 256 down to 2 by rate code.
// RULE_02: Timer A run bit 7 stops or starts counting.
// RULE_03: Timer A counter is 8-bit, readable, writable, resets to zero.
// RULE_04: Timer A wraps FF to 00, keeps counting, raises its request flag.
// RULE_05: Timer A overflows after 256 minus preload ticks.
// RULE_06: Software disables, sets rate, loads counter, enables interrupt, then runs.
// RULE_07: Timer B source bit 3 picks prescaled clock or external pin.
// RULE_08: External source counts once per falling edge on the event pin.
// RULE_09: External source ignores the timer B rate field.
// RULE_10: External source forces the pin's own request flag to zero.
// RULE_11: Timer B wraps FF to 00, keeps counting, raises its request flag.
// RULE_12: In PWM mode the overflow still comes every 256 counts.
// RULE_13: Timer B rate field uses timer A's encoding.
// RULE_14: Timer B run bit 7 stops or starts counting.
// RULE_15: PWM bit 0 drives the pin; reload and toggle bits pick range.
// RULE_16: Toggle bit 1 drives toggle output on pin when PWM is off.
// RULE_17: Auto-reload bit 2 acts only while PWM is off.
// RULE_18: Auto-reload copies reload value into counter on each overflow.
// RULE_19: Timer B counter is 8-bit, read/write, reset zero, 256 minus preload.
// RULE_20: Boundary is 256, or 256/64/32/16 by bit pair in PWM mode.
// RULE_21: Reload value gives interval of N minus value ticks.
// RULE_22: PWM output is high while counter is below reload value.
// RULE_23: Toggle output flips once per overflow, half the overflow rate.
// RULE_24: Disabled timers hold; enabled timers add one per tick.
// RULE_25: Event pin is synchronised and each falling edge counted once.
module dual_timer
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // External event pin
   input wire logic ext_event_pin,
   // Shared wave output pin
   output logic wave_out,
   output logic wave_oe,
   // Interrupt requests towards the CPU
   output logic timer_a_irq_req,
   output logic timer_b_irq_req,
   output logic ext_pin_irq_req
);
   presc_if pa ();
   presc_if pb ();

   byte_t a_ctrl_r, a_cnt_r, b_ctrl_r, b_cnt_r, b_reload_r;
   logic timer_a_irq_flag, timer_a_irq_enable, timer_b_irq_flag, timer_b_irq_enable;
   logic ext_pin_irq_flag;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic toggle_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [9:0] widx, ridx;
   logic wr_go, rd_go;
   logic wr_a_ctrl, wr_a_cnt, wr_b_ctrl, wr_b_cnt, wr_b_reload, wr_irq;
   logic timer_a_run, timer_b_run, timer_b_source_sel;
   logic timer_b_autoreload_en, timer_b_toggle_out_en, timer_b_pwm_en;
   logic ext_fall, tick_a, tick_b, ovf_a, ovf_b, sw_b_ovf, pwm_high;
   byte_t pwm_mask;
   byte_t wbyte;
   wave_sel_t wave_sel;

   prescaler u_presc_a (.clk(clk), .rstn(rstn), .p(pa.gen));
   prescaler u_presc_b (.clk(clk), .rstn(rstn), .p(pb.gen));

   // Control field decode
   assign timer_a_run = a_ctrl_r[`F_RUN];
   assign timer_b_run = b_ctrl_r[`F_RUN];
   assign timer_b_source_sel = b_ctrl_r[`F_SRC];
   assign timer_b_pwm_en = b_ctrl_r[`F_PWM];
   assign timer_b_toggle_out_en = b_ctrl_r[`F_TOGGLE];
   assign timer_b_autoreload_en = b_ctrl_r[`F_ALOAD];
   assign pa.sel = a_ctrl_r[`F_RATE_HI:`F_RATE_LO]; // RULE_01
   assign pb.sel = b_ctrl_r[`F_RATE_HI:`F_RATE_LO]; // RULE_13

   // Bus handshake: address and data are taken together, one write and one read at a time
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   assign rd_go = s_axi_arvalid & ~rvalid_r;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign widx = s_axi_awaddr[11:2];
   assign ridx = s_axi_araddr[11:2];
   assign wbyte = s_axi_wdata[7:0];

   // Write strobes, low byte lane must be enabled
   assign wr_a_ctrl = wr_go & s_axi_wstrb[0] & (widx == {2'b00, `IDX_A_CTRL});
   assign wr_a_cnt = wr_go & s_axi_wstrb[0] & (widx == {2'b00, `IDX_A_CNT});
   assign wr_b_ctrl = wr_go & s_axi_wstrb[0] & (widx == {2'b00, `IDX_B_CTRL});
   assign wr_b_cnt = wr_go & s_axi_wstrb[0] & (widx == {2'b00, `IDX_B_CNT});
   assign wr_b_reload = wr_go & s_axi_wstrb[0] & (widx == {2'b00, `IDX_B_RELOAD});
   assign wr_irq = wr_go & s_axi_wstrb[0] & (widx == {2'b00, `IDX_IRQ});

   // Write response channel
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_a_ctrl | wr_a_cnt | wr_b_ctrl | wr_b_cnt | wr_b_reload | wr_irq |
                     ~s_axi_wstrb[0]) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Read data channel; reload register is write-only and reads zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid_r <= 1'b1;
         rresp_r <= `RESP_OKAY;
         unique case (ridx)
            {2'b00, `IDX_A_CTRL}: rdata_r <= {24'h000000, a_ctrl_r};
            {2'b00, `IDX_A_CNT}: rdata_r <= {24'h000000, a_cnt_r}; // RULE_03
            {2'b00, `IDX_B_CTRL}: rdata_r <= {24'h000000, b_ctrl_r};
            {2'b00, `IDX_B_CNT}: rdata_r <= {24'h000000, b_cnt_r}; // RULE_19
            {2'b00, `IDX_B_RELOAD}: rdata_r <= 32'h0000_0000;
            {2'b00, `IDX_IRQ}: rdata_r <= {27'h0000000, ext_pin_irq_flag, timer_b_irq_enable,
                                           timer_b_irq_flag, timer_a_irq_enable, timer_a_irq_flag};
            default:
            begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= `RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Control and reload registers; timer A keeps only bits 7 to 4
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         a_ctrl_r <= `RST_BYTE;
         b_ctrl_r <= `RST_BYTE;
         b_reload_r <= `RST_BYTE;
      end
      else
      begin
         if (wr_a_ctrl)
            a_ctrl_r <= {wbyte[7:4], 4'h0};
         if (wr_b_ctrl)
            b_ctrl_r <= wbyte;
         if (wr_b_reload)
            b_reload_r <= wbyte;
      end
   end

   // Event pin synchroniser and falling-edge detect on the synchronised level
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ext_s1_r <= 1'b1;
         ext_s2_r <= 1'b1;
         ext_s3_r <= 1'b1;
      end
      else
      begin
         ext_s1_r <= ext_event_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end
   assign ext_fall = ext_s3_r & ~ext_s2_r; // RULE_25

   // Tick selection; the rate field is unused on the external source
   assign tick_a = timer_a_run & pa.tick; // RULE_02
   assign tick_b = timer_b_run & (timer_b_source_sel ? ext_fall : pb.tick); // RULE_07 RULE_08 RULE_09 RULE_14

   // Overflow on the FF to 00 step of the full 8-bit count
   assign ovf_a = tick_a & (a_cnt_r == `CNT_MAX) & ~wr_a_cnt; // RULE_04 RULE_05
   assign ovf_b = tick_b & (b_cnt_r == `CNT_MAX) & ~wr_b_cnt; // RULE_11 RULE_12
   // Software moving the counter off FF also raises the flag
   assign sw_b_ovf = wr_b_cnt & (b_cnt_r == `CNT_MAX) & (wbyte != `CNT_MAX);

   // Timer A counter; a software write wins over a tick
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         a_cnt_r <= `RST_BYTE; // RULE_03
      else if (wr_a_cnt)
         a_cnt_r <= wbyte;
      else if (tick_a)
         a_cnt_r <= a_cnt_r + 8'h01; // RULE_24
   end

   // Timer B counter with auto-reload outside PWM mode
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         b_cnt_r <= `RST_BYTE; // RULE_19
      else if (wr_b_cnt)
         b_cnt_r <= wbyte;
      else if (ovf_b & timer_b_autoreload_en & ~timer_b_pwm_en)
         b_cnt_r <= b_reload_r; // RULE_17 RULE_18 RULE_21
      else if (tick_b)
         b_cnt_r <= b_cnt_r + 8'h01; // RULE_24
   end

   // Request flags; a set in the same cycle as a register-write clear wins, but the external source keeps the pin flag at zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         timer_a_irq_flag <= 1'b0;
         timer_a_irq_enable <= 1'b0;
         timer_b_irq_flag <= 1'b0;
         timer_b_irq_enable <= 1'b0;
         ext_pin_irq_flag <= 1'b0;
      end
      else
      begin
         if (ovf_a)
            timer_a_irq_flag <= 1'b1; // RULE_04
         else if (wr_irq)
            timer_a_irq_flag <= wbyte[`F_A_FLAG];
         if (ovf_b | sw_b_ovf)
            timer_b_irq_flag <= 1'b1; // RULE_11
         else if (wr_irq)
            timer_b_irq_flag <= wbyte[`F_B_FLAG];
         if (timer_b_source_sel)
            ext_pin_irq_flag <= 1'b0; // RULE_10
         else if (ext_fall)
            ext_pin_irq_flag <= 1'b1;
         else if (wr_irq)
            ext_pin_irq_flag <= wbyte[`F_EXT_FLAG];
         if (wr_irq)
         begin
            timer_a_irq_enable <= wbyte[`F_A_IEN];
            timer_b_irq_enable <= wbyte[`F_B_IEN];
         end
      end
   end
   assign timer_a_irq_req = timer_a_irq_flag & timer_a_irq_enable;
   assign timer_b_irq_req = timer_b_irq_flag & timer_b_irq_enable;
   assign ext_pin_irq_req = ext_pin_irq_flag;

   // Toggle output flips once per timer B overflow
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         toggle_r <= 1'b0;
      else if (ovf_b)
         toggle_r <= ~toggle_r; // RULE_23
   end

   // PWM boundary from the reload/toggle bit pair; compare uses the low bits
   always_comb
   begin
      unique case ({timer_b_autoreload_en, timer_b_toggle_out_en})
         2'b00: pwm_mask = `MASK_256;
         2'b01: pwm_mask = `MASK_64;
         2'b10: pwm_mask = `MASK_32;
         2'b11: pwm_mask = `MASK_16;
      endcase
   end
   assign pwm_high = (b_cnt_r & pwm_mask) < (b_reload_r & pwm_mask); // RULE_20 RULE_22

   // Pin function selection
   assign wave_sel = timer_b_pwm_en ? WAVE_PWM : (timer_b_toggle_out_en ? WAVE_TOGGLE : WAVE_IO); // RULE_15 RULE_16

   // Registered pin drive
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wave_out <= 1'b0;
         wave_oe <= 1'b0;
      end
      else
      begin
         wave_oe <= (wave_sel != WAVE_IO);
         wave_out <= (wave_sel == WAVE_PWM) ? pwm_high : ((wave_sel == WAVE_TOGGLE) & toggle_r);
      end
   end

   // Checks
   a_count_step_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_24
      tick_a & ~wr_a_cnt |=> a_cnt_r == $past(a_cnt_r) + 8'h01)
      else $error("timer A did not advance by one");
   a_hold_stop_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
      ~timer_a_run & ~wr_a_cnt |=> $stable(a_cnt_r))
      else $error("stopped timer A changed");
   a_wrap_flag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
      ovf_a |=> timer_a_irq_flag && a_cnt_r == 8'h00)
      else $error("timer A wrap missed flag");
   b_reload_load_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_18
      ovf_b & timer_b_autoreload_en & ~timer_b_pwm_en |=> b_cnt_r == $past(b_reload_r))
      else $error("reload not copied on overflow");
   b_ext_count_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
      timer_b_source_sel & timer_b_run & ext_fall & ~wr_b_cnt & ~(b_cnt_r == 8'hff)
      |=> b_cnt_r == $past(b_cnt_r) + 8'h01)
      else $error("event edge not counted");
   b_ext_rate_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
      timer_b_source_sel & ~ext_fall & ~wr_b_cnt |=> $stable(b_cnt_r))
      else $error("prescaler moved external counter");
   ext_flag_zero_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
      timer_b_source_sel ##1 timer_b_source_sel |-> ~ext_pin_irq_flag)
      else $error("pin flag set under external clock");
   pwm_level_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_22
      timer_b_pwm_en |=> wave_oe && wave_out == $past(pwm_high))
      else $error("pwm level wrong");
   toggle_flip_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_23
      ovf_b |=> toggle_r != $past(toggle_r))
      else $error("toggle did not flip on overflow");
   b_wrap_flag_a: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
      ovf_b |=> timer_b_irq_flag)
      else $error("timer B wrap missed flag");
endmodule : dual_timer

/* File: verif/testbench.sv */
// Self-checking testbench of the dual timer over its register bus and pins
`include "timer_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // Byte addresses are four times the register indices
   localparam logic [11:0] A_CTRL = {2'b00, `IDX_A_CTRL, 2'b00};
   localparam logic [11:0] A_CNT = {2'b00, `IDX_A_CNT, 2'b00};
   localparam logic [11:0] B_CTRL = {2'b00, `IDX_B_CTRL, 2'b00};
   localparam logic [11:0] B_CNT = {2'b00, `IDX_B_CNT, 2'b00};
   localparam logic [11:0] B_RLD = {2'b00, `IDX_B_RELOAD, 2'b00};
   localparam logic [11:0] IRQ_REG = {2'b00, `IDX_IRQ, 2'b00};
   typedef struct {bit b; logic [7:0] ctrl; logic [7:0] rld; int iv; int hi; bit tog;} row_t;
   logic clk, rstn, ext_event_pin, wave_out, wave_oe, timer_a_irq_req, timer_b_irq_req, ext_pin_irq_req;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   int hcnt = 0;
   row_t rows[14];
   logic [31:0] v0, v1;
   logic [1:0] rr;
   // Device under test
   dual_timer u_dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .ext_event_pin(ext_event_pin), .wave_out(wave_out), .wave_oe(wave_oe), .timer_a_irq_req(timer_a_irq_req),
      .timer_b_irq_req(timer_b_irq_req), .ext_pin_irq_req(ext_pin_irq_req));
   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cycle count and count of cycles with the wave pin high
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (wave_out === 1'b1) hcnt <= hcnt + 1;
   end
   // Compare and report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk
   // Verdict and end of run
   task automatic test_done();
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // Bus write: address and data offered together, each released when taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      bit aw_done;
      bit w_done;
      n = 0;
      aw_done = 0;
      w_done = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (!aw_done && s_axi_awready === 1'b1)
         begin
            aw_done = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1)
         begin
            w_done = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      chk("write_answered", 1, s_axi_bvalid);
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : axi_write
   // Bus read
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      bit ar_done;
      n = 0;
      ar_done = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (!ar_done && s_axi_arready === 1'b1)
         begin
            ar_done = 1;
            s_axi_arvalid <= 1'b0;
         end
      end
      while (s_axi_rvalid !== 1'b1 && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk("read_answered", 1, s_axi_rvalid);
   endtask : axi_read
   // Read and compare data and response
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      chk(nm, e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask : rd_chk
   // Wait for a timer request to be high, bounded
   task automatic wait_req(input bit b);
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (((b ? timer_b_irq_req : timer_a_irq_req) !== 1'b1) && n < 10000);
      chk("irq_seen", 1, b ? timer_b_irq_req : timer_a_irq_req);
   endtask : wait_req
   // Interval between two overflows, with pin high count and toggle
   task automatic measure(input row_t r);
      int t0;
      int h0;
      logic w0;
      axi_write(IRQ_REG, 32'h0a, `RESP_OKAY);
      wait_req(r.b);
      axi_write(IRQ_REG, 32'h0a, `RESP_OKAY);
      wait_req(r.b);
      t0 = cyc;
      h0 = hcnt;
      w0 = wave_out;
      axi_write(IRQ_REG, 32'h0a, `RESP_OKAY);
      wait_req(r.b);
      chk("interval", r.iv, cyc - t0);
      if (r.hi >= 0) chk("pwm_high", r.hi, hcnt - h0);
      if (r.tog) chk("toggle", {31'h0, ~w0}, {31'h0, wave_out});
      if (r.b) chk("wave_oe", 1, wave_oe);
   endtask : measure
   // One falling edge on the event pin, low and high for three cycles each
   task automatic pulse();
      @(posedge clk);
      ext_event_pin <= 1'b0;
      repeat (3) @(posedge clk);
      ext_event_pin <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : pulse
   // All registers, the three request outputs and wave_oe at their reset values
   task automatic defaults();
      rd_chk(A_CTRL, 0, `RESP_OKAY, "a_ctrl");
      rd_chk(A_CNT, 0, `RESP_OKAY, "a_cnt");
      rd_chk(B_CTRL, 0, `RESP_OKAY, "b_ctrl");
      rd_chk(B_CNT, 0, `RESP_OKAY, "b_cnt");
      rd_chk(B_RLD, 0, `RESP_OKAY, "b_rld");
      rd_chk(IRQ_REG, 0, `RESP_OKAY, "irq");
      chk("oe_idle", 0, {timer_a_irq_req, timer_b_irq_req, ext_pin_irq_req, wave_oe});
   endtask : defaults
   // Hang guard, well above the expected run length
   initial
   begin
      #2500000;
      fails++;
      test_done();
   end
   // Main sequence
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      ext_event_pin = 1'b1;
      rstn = 1'b0;
      for (int c = 0; c < 8; c++) rows[c] = '{1, 8'(8'h86 | (c << 4)), 8'hf0, 16 << (8 - c), -1, 1};
      rows[8] = '{1, 8'hf1, 8'h08, 512, 16, 0};
      rows[9] = '{1, 8'hf3, 8'h08, 512, 64, 0};
      rows[10] = '{1, 8'hf5, 8'h08, 512, 128, 0};
      rows[11] = '{1, 8'hf7, 8'h08, 512, 256, 0};
      rows[12] = '{0, 8'hf0, 8'h00, 512, -1, 0};
      rows[13] = '{0, 8'he0, 8'h00, 1024, -1, 0};
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      defaults();
      // Access kinds: unused bits, write-only reload, unmapped place
      axi_write(A_CTRL, 32'h7f, `RESP_OKAY);
      rd_chk(A_CTRL, 32'h70, `RESP_OKAY, "a_ctrl_bits");
      axi_write(A_CNT, 32'h5a, `RESP_OKAY);
      rd_chk(A_CNT, 32'h5a, `RESP_OKAY, "a_cnt_rw");
      // A write with the low byte lane off leaves the counter alone
      s_axi_wstrb <= 4'he;
      axi_write(A_CNT, 32'h77, `RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd_chk(A_CNT, 32'h5a, `RESP_OKAY, "a_cnt_lane");
      axi_write(B_CNT, 32'ha5, `RESP_OKAY);
      rd_chk(B_CNT, 32'ha5, `RESP_OKAY, "b_cnt_rw");
      axi_write(B_RLD, 32'h33, `RESP_OKAY);
      rd_chk(B_RLD, 0, `RESP_OKAY, "b_rld_wo");
      axi_write(12'hffc, 32'h11, `RESP_SLVERR);
      rd_chk(12'hffc, 0, `RESP_SLVERR, "unmapped");
      // Overflow intervals, toggle and PWM rows
      for (int i = 0; i < 14; i++)
      begin
         if (rows[i].b)
         begin
            axi_write(B_CTRL, 0, `RESP_OKAY);
            axi_write(B_RLD, {24'h0, rows[i].rld}, `RESP_OKAY);
            axi_write(B_CNT, {24'h0, rows[i].rld}, `RESP_OKAY);
            axi_write(B_CTRL, {24'h0, rows[i].ctrl}, `RESP_OKAY);
         end
         else axi_write(A_CTRL, {24'h0, rows[i].ctrl}, `RESP_OKAY);
         measure(rows[i]);
      end
      // Stopped timer holds its count
      axi_write(A_CTRL, 32'h70, `RESP_OKAY);
      axi_write(B_CTRL, 0, `RESP_OKAY);
      axi_read(A_CNT, v0, rr);
      repeat (40) @(posedge clk);
      rd_chk(A_CNT, v0, `RESP_OKAY, "a_hold");
      // Event counting across the wrap, rate field set but ignored
      axi_write(B_CNT, 32'hfd, `RESP_OKAY);
      axi_write(IRQ_REG, 32'h0a, `RESP_OKAY);
      axi_write(B_CTRL, 32'hf8, `RESP_OKAY);
      repeat (5) pulse();
      repeat (4) @(posedge clk);
      axi_write(B_CTRL, 32'h78, `RESP_OKAY);
      rd_chk(B_CNT, 32'h02, `RESP_OKAY, "events");
      axi_read(IRQ_REG, v1, rr);
      chk("b_flag", 1, v1[`F_B_FLAG]);
      chk("ext_flag", 0, v1[`F_EXT_FLAG]);
      chk("ext_req", 0, ext_pin_irq_req);
      // Internal source: the pin raises its own request again
      axi_write(B_CTRL, 0, `RESP_OKAY);
      pulse();
      repeat (4) @(posedge clk);
      chk("ext_req_int", 1, ext_pin_irq_req);
      // Reset in mid-run clears everything
      axi_write(A_CTRL, 32'hf0, `RESP_OKAY);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      defaults();
      test_done();
   end
endmodule : testbench
